//--- design/nvb_array.sv
// Byte storage array of the nonvolatile access unit.
`default_nettype none

module nvb_array
    import nvb_pkg::*;
(
    input wire logic aclk,
    input wire nvb_wr_t wr,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);

    // Cells keep their value across reset, as nonvolatile storage would.
    logic [7:0] mem_q [256];

    always_ff @(posedge aclk)
    begin
        if (wr.en)
        begin
            mem_q[wr.addr] <= wr.data;
        end
    end

    assign rd_data = mem_q[rd_addr];

endmodule : nvb_array

`default_nettype wire

//--- design/nvb_top.sv
// Top of the nonvolatile byte access unit with its AXI4-Lite register slave.
`default_nettype none

// Notes on behaviour
// - Read strobe loads data register next cycle.
// - Data register holds until read, written or cleared by an abort event.
// - Write starts only after exact unlock sequence.
// - Wrong cycle count in sequence blocks write.
// - Write strobe refused without write permit.
// - Hardware never clears the write permit.
// - Clearing permit leaves running write intact.
// - Completion clears strobe, sets done flag.
// - Done flag stays until software clears.
// - Power-up clears the write permit.
// - Power-up timer blocks writes for 64 ms.
// - Protect fuse leaves processor access working.
// - Unlock port stores nothing.
// - Strobes are set-only, hardware clears them.
// - Reset during write sets abort, clears registers.
// - Array holds 256 bytes, 8-bit address.
// - Unlock port reads as zero.
module nvb_top
    import nvb_pkg::*;
#(
    parameter int unsigned PWRUP_CYC = NVB_PWRUP_CYC,
    parameter int unsigned WRITE_CYC = NVB_WRITE_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_master_reset_n,
    input wire logic watchdog_timeout,
    input wire logic data_protect_fuse
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic nvb_mapped(input logic [31:0] a);
        logic [7:0] i;
        i = a[9:2];
        nvb_mapped = (a[31:10] == 22'h0) && (a[1:0] == 2'h0)
            && (i == NVB_IDX_IRQ_FLAGS || i == NVB_IDX_IRQ_EN || i == NVB_IDX_DATA
                || i == NVB_IDX_ADDR || i == NVB_IDX_CTRL || i == NVB_IDX_UNLOCK
                || i == NVB_IDX_STATUS);
    endfunction : nvb_mapped

    // ****************************************
    // State
    // ****************************************
    logic aw_hold_q, w_hold_q, aw_ok_q, w_strb_q;
    logic [7:0] aw_idx_q, w_byte_q;
    logic [7:0] data_q, addr_q, irq_en_q;
    logic rd_q, wr_q, permit_q, abort_q, done_q;
    logic [NVB_CNT_W-1:0] wcnt_q, pwr_cnt_q;
    logic [2:0] mrst_sync_q, wdt_sync_q, fuse_sync_q;
    logic mrst_q, wdt_q, fuse_q;
    logic wr_go, wr_fire, abort_evt, armed, start_ok, finish;
    logic [7:0] arr_rdata, rd_byte;
    nvb_wr_t arr_wr;
    nvb_bus_wr_t bus_wr;

    assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_fire = wr_go && aw_ok_q && w_strb_q;
    assign finish = wr_q && (wcnt_q == '0) && !abort_evt;
    assign start_ok = permit_q && armed && (pwr_cnt_q == '0) && !wr_q;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // A level counts once the second and third stages agree.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mrst_sync_q <= 3'h7;
            wdt_sync_q <= 3'h0;
            fuse_sync_q <= 3'h0;
            mrst_q <= 1'b0;
            wdt_q <= 1'b0;
            fuse_q <= 1'b0;
        end
        else
        begin
            mrst_sync_q <= {mrst_sync_q[1:0], external_master_reset_n};
            wdt_sync_q <= {wdt_sync_q[1:0], watchdog_timeout};
            fuse_sync_q <= {fuse_sync_q[1:0], data_protect_fuse};
            if (mrst_sync_q[1] == mrst_sync_q[2])
            begin
                mrst_q <= !mrst_sync_q[2];
            end
            if (wdt_sync_q[1] == wdt_sync_q[2])
            begin
                wdt_q <= wdt_sync_q[2];
            end
            if (fuse_sync_q[1] == fuse_sync_q[2])
            begin
                fuse_q <= fuse_sync_q[2];
            end
        end
    end

    assign abort_evt = (mrst_sync_q[1] == mrst_sync_q[2] && !mrst_sync_q[2] && !mrst_q)
        || (wdt_sync_q[1] == wdt_sync_q[2] && wdt_sync_q[2] && !wdt_q);

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= NVB_RESP_OKAY;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_ok_q <= 1'b0;
            aw_idx_q <= 8'h00;
            w_byte_q <= 8'h00;
            w_strb_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_idx_q <= s_axi_awaddr[9:2];
                aw_ok_q <= nvb_mapped(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                s_axi_wready <= 1'b0;
                w_byte_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_ok_q ? NVB_RESP_OKAY : NVB_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (s_axi_araddr[9:2])
            NVB_IDX_IRQ_FLAGS: rd_byte[NVB_IRQ_DONE] = done_q;
            NVB_IDX_IRQ_EN: rd_byte = irq_en_q;
            NVB_IDX_DATA: rd_byte = data_q;
            NVB_IDX_ADDR: rd_byte = addr_q;
            NVB_IDX_CTRL: rd_byte = {4'h0, abort_q, permit_q, wr_q, rd_q};
            NVB_IDX_STATUS: rd_byte = {5'h00, wr_q, pwr_cnt_q != '0, fuse_q};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= NVB_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nvb_mapped(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h0000_0000;
            s_axi_rresp <= nvb_mapped(s_axi_araddr) ? NVB_RESP_OKAY : NVB_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // Data and address registers
    // ****************************************
    // Bus writes to these registers are ignored while a byte is being
    // programmed, but a read strobe still reloads data_q and so changes the byte in flight.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || abort_evt)
        begin
            data_q <= NVB_BYTE_RESET;
            addr_q <= NVB_BYTE_RESET;
        end
        else
        begin
            if (rd_q)
            begin
                data_q <= arr_rdata;
            end
            else if (wr_fire && aw_idx_q == NVB_IDX_DATA && !wr_q)
            begin
                data_q <= w_byte_q;
            end
            if (wr_fire && aw_idx_q == NVB_IDX_ADDR && !wr_q)
            begin
                addr_q <= w_byte_q;
            end
        end
    end

    // ****************************************
    // Control strobes and flags
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_q <= 1'b0;
            permit_q <= 1'b0;
            abort_q <= 1'b0;
        end
        else
        begin
            rd_q <= wr_fire && aw_idx_q == NVB_IDX_CTRL && w_byte_q[NVB_CTRL_RD];
            if (wr_fire && aw_idx_q == NVB_IDX_CTRL)
            begin
                permit_q <= w_byte_q[NVB_CTRL_PERMIT];
            end
            if (abort_evt && wr_q)
            begin
                abort_q <= 1'b1;
            end
            else if (wr_fire && aw_idx_q == NVB_IDX_CTRL)
            begin
                abort_q <= w_byte_q[NVB_CTRL_ABORT];
            end
        end
    end

    // The write strobe can only be set by software; a cleared bit in the
    // written byte is ignored, so only an abort event or reset cuts a running write short.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_q <= 1'b0;
            wcnt_q <= '0;
        end
        else if (abort_evt)
        begin
            wr_q <= 1'b0;
        end
        else if (finish)
        begin
            wr_q <= 1'b0;
        end
        else if (wr_q)
        begin
            wcnt_q <= wcnt_q - 1'b1;
        end
        else if (wr_fire && aw_idx_q == NVB_IDX_CTRL && w_byte_q[NVB_CTRL_WR] && start_ok)
        begin
            wr_q <= 1'b1;
            wcnt_q <= NVB_CNT_W'(WRITE_CYC - 1);
        end
    end

    // Completion sets the flag even in the cycle software clears it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_q <= 1'b0;
            irq_en_q <= 8'h00;
        end
        else
        begin
            if (finish)
            begin
                done_q <= 1'b1;
            end
            else if (wr_fire && aw_idx_q == NVB_IDX_IRQ_FLAGS)
            begin
                done_q <= w_byte_q[NVB_IRQ_DONE];
            end
            if (wr_fire && aw_idx_q == NVB_IDX_IRQ_EN)
            begin
                irq_en_q <= w_byte_q & 8'h80;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwr_cnt_q <= NVB_CNT_W'(PWRUP_CYC);
        end
        else if (pwr_cnt_q != '0)
        begin
            pwr_cnt_q <= pwr_cnt_q - 1'b1;
        end
    end

    // ****************************************
    // Submodules
    // ****************************************
    assign bus_wr = '{valid: wr_fire, to_unlock: aw_idx_q == NVB_IDX_UNLOCK, data: w_byte_q};
    assign arr_wr = '{en: finish, addr: addr_q, data: data_q};

    nvb_unlock u_unlock (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus_wr(bus_wr),
        .armed(armed)
    );

    nvb_array u_array (
        .aclk(aclk),
        .wr(arr_wr),
        .rd_addr(addr_q),
        .rd_data(arr_rdata)
    );

    // ****************************************
    // Assertions
    // ****************************************
    property p_rd_next;
        @(posedge aclk) disable iff (!aresetn)
        rd_q && !abort_evt |=> data_q == $past(arr_rdata);
    endproperty
    a_rd_next: assert property (p_rd_next) else $error("read data not loaded");

    property p_data_hold;
        @(posedge aclk) disable iff (!aresetn)
        !rd_q && !abort_evt && !(wr_fire && aw_idx_q == NVB_IDX_DATA) |=> $stable(data_q);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data changed");

    property p_armed_start;
        @(posedge aclk) disable iff (!aresetn)
        $rose(wr_q) |-> $past(armed) && $past(permit_q);
    endproperty
    a_armed_start: assert property (p_armed_start) else $error("unguarded start");

    property p_permit_sw;
        @(posedge aclk) disable iff (!aresetn)
        $fell(permit_q) |-> $past(wr_fire) && $past(aw_idx_q) == NVB_IDX_CTRL;
    endproperty
    a_permit_sw: assert property (p_permit_sw) else $error("permit cleared");

    property p_write_runs;
        @(posedge aclk) disable iff (!aresetn)
        wr_q && wcnt_q != '0 && !abort_evt |=> wr_q && wcnt_q == $past(wcnt_q) - 1'b1;
    endproperty
    a_write_runs: assert property (p_write_runs) else $error("write cut short");

    property p_done;
        @(posedge aclk) disable iff (!aresetn)
        finish |=> !wr_q && done_q;
    endproperty
    a_done: assert property (p_done) else $error("completion missed");

    property p_done_sticky;
        @(posedge aclk) disable iff (!aresetn)
        done_q && !(wr_fire && aw_idx_q == NVB_IDX_IRQ_FLAGS) |=> done_q;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    property p_pwrup;
        @(posedge aclk) disable iff (!aresetn)
        $rose(wr_q) |-> $past(pwr_cnt_q) == '0;
    endproperty
    a_pwrup: assert property (p_pwrup) else $error("write during power-up");

    property p_abort;
        @(posedge aclk) disable iff (!aresetn)
        abort_evt && wr_q |=> abort_q && !wr_q && data_q == 8'h00 && addr_q == 8'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not handled");

    property p_unlock_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == {22'h0, NVB_IDX_UNLOCK, 2'h0}
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero) else $error("unlock read nonzero");

endmodule : nvb_top

`default_nettype wire

//--- design/nvb_unlock.sv
// Unlock sequence tracker for byte writes.
`default_nettype none

module nvb_unlock
    import nvb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire nvb_bus_wr_t bus_wr,
    output logic armed
);

    typedef enum logic [1:0] {NVB_UL_IDLE, NVB_UL_FIRST, NVB_UL_ARMED} nvb_ul_state_t;

    nvb_ul_state_t state_q;
    logic [7:0] gap_q;

    // Each step must follow the previous one within a fixed cycle count.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= NVB_UL_IDLE;
            gap_q <= 8'h00;
        end
        else if (bus_wr.valid)
        begin
            gap_q <= 8'h00;
            if (bus_wr.to_unlock && bus_wr.data == NVB_KEY_FIRST)
            begin
                state_q <= NVB_UL_FIRST;
            end
            else if (bus_wr.to_unlock && bus_wr.data == NVB_KEY_SECOND
                     && state_q == NVB_UL_FIRST)
            begin
                state_q <= NVB_UL_ARMED;
            end
            else
            begin
                state_q <= NVB_UL_IDLE;
            end
        end
        else if (state_q != NVB_UL_IDLE)
        begin
            gap_q <= gap_q + 8'h01;
            if (gap_q >= 8'(NVB_UNLOCK_GAP_CYC - 1))
            begin
                state_q <= NVB_UL_IDLE;
            end
        end
    end

    assign armed = (state_q == NVB_UL_ARMED);

endmodule : nvb_unlock

`default_nettype wire

//--- pkg/nvb_pkg.sv
// Package of constants and carrier types for the nonvolatile byte access unit.
`default_nettype none

package nvb_pkg;

    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] NVB_IDX_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] NVB_IDX_IRQ_EN = 8'h8C;
    localparam logic [7:0] NVB_IDX_DATA = 8'h9A;
    localparam logic [7:0] NVB_IDX_ADDR = 8'h9B;
    localparam logic [7:0] NVB_IDX_CTRL = 8'h9C;
    localparam logic [7:0] NVB_IDX_UNLOCK = 8'h9D;
    localparam logic [7:0] NVB_IDX_STATUS = 8'h9E;

    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int NVB_CTRL_RD = 0;
    localparam int NVB_CTRL_WR = 1;
    localparam int NVB_CTRL_PERMIT = 2;
    localparam int NVB_CTRL_ABORT = 3;
    localparam int NVB_IRQ_DONE = 7;
    localparam int NVB_STAT_FUSE = 0;
    localparam int NVB_STAT_PWRUP = 1;
    localparam int NVB_STAT_BUSY = 2;
    localparam logic [7:0] NVB_KEY_FIRST = 8'h55;
    localparam logic [7:0] NVB_KEY_SECOND = 8'hAA;
    localparam logic [7:0] NVB_BYTE_RESET = 8'h00;
    localparam logic [1:0] NVB_RESP_OKAY = 2'h0;
    localparam logic [1:0] NVB_RESP_SLVERR = 2'h2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int NVB_CLK_NS = 40;
    localparam int NVB_PWRUP_MS = 64;
    localparam int NVB_PWRUP_CYC = NVB_PWRUP_MS * 1000000 / NVB_CLK_NS;
    localparam int NVB_WRITE_NS = 5000000;
    localparam int NVB_WRITE_CYC = (NVB_WRITE_NS + NVB_CLK_NS - 1) / NVB_CLK_NS;
    localparam int NVB_UNLOCK_GAP_NS = 2000;
    localparam int NVB_UNLOCK_GAP_CYC = NVB_UNLOCK_GAP_NS / NVB_CLK_NS;
    localparam int NVB_CNT_W = 21;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } nvb_wr_t;

    typedef struct packed {
        logic valid;
        logic to_unlock;
        logic [7:0] data;
    } nvb_bus_wr_t;

endpackage : nvb_pkg

`default_nettype wire

//--- tb/nvb_tb.sv
// Self-checking testbench of the nonvolatile byte access unit.
`default_nettype none

module testbench
    import nvb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Set-up
    // ****************************************
    // Short counts keep the run brief; every expectation below follows from them.
    localparam int PW = 80;
    localparam int WC = 20;
    localparam logic [7:0] CT = NVB_IDX_CTRL;
    localparam logic [7:0] DA = NVB_IDX_DATA;
    localparam logic [7:0] AD = NVB_IDX_ADDR;
    localparam logic [7:0] UL = NVB_IDX_UNLOCK;
    localparam logic [7:0] FL = NVB_IDX_IRQ_FLAGS;
    localparam logic [7:0] ST = NVB_IDX_STATUS;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic external_master_reset_n = 1'b1;
    logic watchdog_timeout = 1'b0;
    logic data_protect_fuse = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [1:0] rresp_seen;
    logic [1:0] bresp_seen;
    int fail_count = 0;
    int checked = 0;

    nvb_top #(.PWRUP_CYC(PW), .WRITE_CYC(WC)) uut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .external_master_reset_n, .watchdog_timeout, .data_protect_fuse);

    always #20 aclk = ~aclk;

    // ****************************************
    // Bus and comparison tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    // A bus or poll limit that runs out is a mismatch, not a silent pass.
    task automatic timed_out;
        fail_count++;
        $display("[FAIL] %0t ns: no answer in time", $time);
    endtask : timed_out

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 300);
        if (s_axi_bvalid !== 1'b1)
            timed_out();
        bresp_seen = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] v);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {22'h0, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        while (s_axi_rvalid !== 1'b1 && n < 300);
        if (s_axi_rvalid !== 1'b1)
            timed_out();
        v = s_axi_rdata;
        rresp_seen = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        rd(idx, v);
        check(v, {24'h0, exp});
    endtask : expect_reg

    task automatic start(input logic [7:0] a, input logic [7:0] d);
        wr(AD, a);
        wr(DA, d);
        wr(CT, 8'h04);
        wr(UL, NVB_KEY_FIRST);
        wr(UL, NVB_KEY_SECOND);
        wr(CT, 8'h06);
    endtask : start

    task automatic poll(input logic [7:0] idx, input int bitpos);
        logic [31:0] v;
        int n;
        n = 0;
        do
        begin
            rd(idx, v);
            n++;
        end
        while (v[bitpos] !== 1'b0 && n < 200);
        if (v[bitpos] !== 1'b0)
            timed_out();
    endtask : poll

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [31:0] v;
        expect_reg(CT, 8'h00);
        expect_reg(ST, 8'h02);
        expect_reg(UL, 8'h00);
        check({30'h0, rresp_seen}, {30'h0, NVB_RESP_OKAY});
        wr(UL, 8'h5A);
        check({30'h0, bresp_seen}, {30'h0, NVB_RESP_OKAY});
        expect_reg(UL, 8'h00);
        rd(8'h10, v);
        check({30'h0, rresp_seen}, {30'h0, NVB_RESP_SLVERR});
        check(v, 32'h0000_0000);
        wr(8'h10, 8'hFF);
        check({30'h0, bresp_seen}, {30'h0, NVB_RESP_SLVERR});
        wr(NVB_IDX_IRQ_EN, 8'h80);
        expect_reg(NVB_IDX_IRQ_EN, 8'h80);
    endtask : t_reset

    task automatic t_pwrup;
        start(8'h10, 8'h3C);
        expect_reg(CT, 8'h04);
        poll(ST, NVB_STAT_PWRUP);
        expect_reg(ST, 8'h00);
        wr(CT, 8'h00);
        wr(UL, NVB_KEY_FIRST);
        wr(UL, NVB_KEY_SECOND);
        wr(CT, 8'h02);
        expect_reg(CT, 8'h00);
    endtask : t_pwrup

    task automatic t_write;
        data_protect_fuse <= 1'b1;
        start(8'hFF, 8'hA5);
        expect_reg(CT, 8'h06);
        wr(DA, 8'h5A);
        wr(CT, 8'h00);
        expect_reg(CT, 8'h02);
        expect_reg(ST, 8'h05);
        poll(CT, NVB_CTRL_WR);
        expect_reg(CT, 8'h00);
        expect_reg(FL, 8'h80);
        wr(AD, 8'hFF);
        wr(CT, 8'h01);
        expect_reg(CT, 8'h00);
        expect_reg(DA, 8'hA5);
        wr(AD, 8'h00);
        expect_reg(DA, 8'hA5);
        s_axi_wstrb <= 4'hE;
        wr(DA, 8'h99);
        s_axi_wstrb <= 4'hF;
        check({30'h0, bresp_seen}, {30'h0, NVB_RESP_OKAY});
        expect_reg(DA, 8'hA5);
        start(8'h00, 8'hC3);
        poll(CT, NVB_CTRL_WR);
        expect_reg(CT, 8'h04);
        expect_reg(FL, 8'h80);
        wr(FL, 8'h00);
        expect_reg(FL, 8'h00);
        wr(CT, 8'h05);
        expect_reg(DA, 8'hC3);
    endtask : t_write

    task automatic bad(input logic [7:0] k1, input logic [7:0] k2, input int gap, input bit extra);
        wr(DA, 8'h11);
        wr(CT, 8'h04);
        wr(UL, k1);
        if (extra)
            wr(AD, 8'h00);
        repeat (gap) @(posedge aclk);
        wr(UL, k2);
        wr(CT, 8'h06);
        expect_reg(CT, 8'h04);
    endtask : bad

    task automatic t_refuse;
        bad(NVB_KEY_SECOND, NVB_KEY_FIRST, 0, 1'b0);
        bad(NVB_KEY_FIRST, NVB_KEY_SECOND, 0, 1'b1);
        bad(NVB_KEY_FIRST, NVB_KEY_SECOND, 60, 1'b0);
        expect_reg(FL, 8'h00);
        wr(CT, 8'h05);
        expect_reg(DA, 8'hC3);
    endtask : t_refuse

    task automatic t_abort;
        start(8'h20, 8'h77);
        external_master_reset_n <= 1'b0;
        repeat (2) @(posedge aclk);
        external_master_reset_n <= 1'b1;
        repeat (8) @(posedge aclk);
        expect_reg(CT, 8'h0C);
        expect_reg(DA, 8'h00);
        expect_reg(AD, 8'h00);
        wr(AD, 8'h33);
        watchdog_timeout <= 1'b1;
        repeat (2) @(posedge aclk);
        watchdog_timeout <= 1'b0;
        repeat (8) @(posedge aclk);
        expect_reg(AD, 8'h00);
    endtask : t_abort

    // ****************************************
    // Sequence and verdict
    // ****************************************
    task report_and_stop;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_pwrup();
        t_write();
        t_refuse();
        t_abort();
        report_and_stop();
    end

    // The whole run needs a few hundred cycles, so this span only trips on a hang.
    initial
    begin
        #400000;
        fail_count++;
        report_and_stop();
    end

endmodule : testbench

`default_nettype wire
